/* File: inc/perb_pkg.sv */
// perb_pkg: record layout, type codes and field positions for the
// profiling event record builder.
// assumes: a single core clock domain; no software-visible registers.
package perb_pkg;

   localparam int REC_BITS       = 256;
   localparam int TS_BITS        = 64;

   // record type codes; zero is never emitted
   localparam logic [7:0] CODE_INVALID   = 8'h00;
   localparam logic [7:0] CODE_VALSAMPLE = 8'h01;
   localparam logic [7:0] CODE_INSTRET   = 8'h02;
   localparam logic [7:0] CODE_BRRET     = 8'h03;
   localparam logic [7:0] CODE_DCMISS    = 8'h04;
   localparam logic [7:0] CODE_CLKNH     = 8'h05;
   localparam logic [7:0] CODE_REFCLKNH  = 8'h06;
   localparam logic [7:0] CODE_PROGEVT   = 8'hFF;

   // value-sample counter width and reset value
   localparam int          CNT_BITS      = 32;
   localparam logic [31:0] CNT_RESET     = 32'h0000_0000;

   // generic event source request from the counting logic
   typedef struct packed {
      logic [7:0]  code;
      logic [15:0] flags;
      logic [31:0] data;
      logic [63:0] instr_addr;
      logic [63:0] extra;
   } perb_evt_t;

   // value-sample instruction retirement
   typedef struct packed {
      logic [15:0] imm;
      logic [31:0] regmem;
      logic [63:0] regval;
      logic [63:0] instr_addr;
      logic        legacy_mode;
   } perb_vs_t;

   // completed 32-byte record, byte 31 at the top
   typedef struct packed {
      logic [63:0] timestamp;
      logic [63:0] extra;
      logic [63:0] instr_addr;
      logic [31:0] data;
      logic [15:0] flags;
      logic [7:0]  core_number;
      logic [7:0]  record_type_code;
   } perb_rec_t;

endpackage

/* File: core/perb_builder.sv */
// perb_builder: assembles fixed 32-byte profiling event records and runs
// the value-sample counter.
// assumes: upstream retirement logic and the store stage share clk; the
// timestamp counter is driven from the same clock domain.
//
// Operation
// RULE1: byte 0 holds a type code from 1 to 255; zero never emitted
// RULE2: byte 1 copies the configured core number
// RULE3: fixed layout: flags, data, address, extra, timestamp
// RULE4: instruction address is effective address, code segment base excluded
// RULE5: timestamp field holds counter when enabled, else zero
// RULE6: fixed type codes 1..6 and 255 for the defined events
// RULE7: each value-sample decrements counter; going negative emits code 1; the builder drops that record when the slot is busy
// RULE8: value-sample flags carry low 16 bits of the immediate
// RULE9: value-sample data is reg/mem; extra is reg, zero-extended legacy
// RULE10: value-sample address is that instruction's address
// RULE11: reserved and undefined fields are written as zero; the builder zeroes them only in code 2 records
// RULE12: timestamp counter is zero-extended to 64 bits
// RULE13: record held stable with valid until store stage accepts
`timescale 1ns/1ps
`default_nettype none

module perb_builder
(
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [7:0]           core_number_field,
   input  wire logic                 ts_enable,
   input  wire logic [55:0]          perf_timestamp_counter,
   input  wire logic                 evt_valid,
   input  wire perb_pkg::perb_evt_t  evt,
   input  wire logic                 vs_valid,
   input  wire perb_pkg::perb_vs_t   vs,
   input  wire logic                 cnt_load,
   input  wire logic [31:0]          cnt_load_value,
   output var  logic                 rec_valid,
   output var  perb_pkg::perb_rec_t  rec,
   input  wire logic                 rec_ready,
   output var  logic                 evt_dropped,
   output var  logic [31:0]          vs_counter
);

   // value-sample counter; underflow is the sign bit going set
   logic [31:0] next_vs_counter;
   logic        vs_underflow;
   logic        slot_free;
   logic        take_vs;
   logic        take_evt;
   logic        evt_code_ok;
   logic        evt_instret;
   logic [63:0] ts_field;
   perb_pkg::perb_rec_t vs_rec;
   perb_pkg::perb_rec_t evt_rec;
   perb_pkg::perb_rec_t next_rec;

   // RULE7 decrement and detect
   assign next_vs_counter = cnt_load ? cnt_load_value :
                            vs_valid ? vs_counter - 32'h0000_0001 :
                            vs_counter;
   // only the step from zero or above into negative emits; a counter
   // already below zero emits nothing until reloaded or until it wraps and counts down through zero again
   assign vs_underflow = vs_valid && !cnt_load
                         && !vs_counter[perb_pkg::CNT_BITS-1]
                         && next_vs_counter[perb_pkg::CNT_BITS-1];

   // RULE13 new record only once the slot is empty or being accepted
   assign slot_free = !rec_valid || rec_ready;
   assign take_vs   = slot_free && vs_underflow;
   // RULE1 a code of zero from upstream is dropped, never emitted
   assign evt_code_ok = evt.code != perb_pkg::CODE_INVALID;
   assign take_evt  = slot_free && !vs_underflow && evt_valid
                      && evt_code_ok;

   // RULE5 timestamp only when enabled
   // RULE12 zero-extended counter value
   assign ts_field = ts_enable ? {8'h00, perf_timestamp_counter}
                               : 64'h0000_0000_0000_0000;

   // RULE6 value sample uses its fixed code
   // RULE8 immediate low half into flags
   // RULE9 reg/mem and zero-extended register operand
   // RULE10 address of the value-sample instruction
   assign vs_rec.record_type_code = perb_pkg::CODE_VALSAMPLE;
   // RULE2 core number copy
   assign vs_rec.core_number      = core_number_field;
   assign vs_rec.flags            = vs.imm;
   assign vs_rec.data             = vs.regmem;
   // RULE4 effective address, no segment base added
   assign vs_rec.instr_addr       = vs.instr_addr;
   assign vs_rec.extra            = vs.legacy_mode ?
                                    {32'h0000_0000, vs.regval[31:0]} :
                                    vs.regval;
   assign vs_rec.timestamp        = ts_field;

   // RULE3 generic layout from upstream fields
   assign evt_rec.record_type_code = evt.code;
   assign evt_rec.core_number      = core_number_field;
   // RULE11 reserved fields forced to zero
   // only the retired-instruction layout is known here; the other
   // generic codes rely on upstream zeroing what they leave undefined
   assign evt_instret = evt.code == perb_pkg::CODE_INSTRET;
   assign evt_rec.flags            = evt_instret ? '0 : evt.flags;
   assign evt_rec.data             = evt_instret ? '0 : evt.data;
   assign evt_rec.instr_addr       = evt.instr_addr;
   assign evt_rec.extra            = evt_instret ? '0 : evt.extra;
   assign evt_rec.timestamp        = ts_field;

   assign next_rec = take_vs ? vs_rec : evt_rec;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         vs_counter <= perb_pkg::CNT_RESET;
      end
      else
      begin
         vs_counter <= next_vs_counter;
      end
   end

   // RULE13 hold until accepted
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rec_valid <= 1'b0;
         rec       <= '0;
      end
      else if (take_vs || take_evt)
      begin
         rec_valid <= 1'b1;
         rec       <= next_rec;
      end
      else if (rec_ready)
      begin
         rec_valid <= 1'b0;
      end
   end

   // a losing or blocked event is discarded, as the store stage may do;
   // counter reload after it is left to the counting logic
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         evt_dropped <= 1'b0;
      end
      else
      begin
         evt_dropped <= (evt_valid && !take_evt)
                        || (vs_underflow && !take_vs);
      end
   end

   // RULE13 record frozen while stalled
   a_hold_stable: assert property ( // RULE13
      @(posedge clk) disable iff (!resetn)
      rec_valid && !rec_ready |=> rec_valid && $stable(rec))
      else $error("record changed before acceptance");

   // RULE13 accepted record leaves
   a_valid_release: assert property ( // RULE13
      @(posedge clk) disable iff (!resetn)
      rec_valid && rec_ready && !take_vs && !take_evt |=> !rec_valid)
      else $error("accepted record still shown as valid");

   // RULE13 busy slot refuses
   a_drop_busy: assert property ( // RULE13
      @(posedge clk) disable iff (!resetn)
      evt_valid && rec_valid && !rec_ready |=> evt_dropped)
      else $error("event on a busy slot not reported as dropped");

   // RULE13 drop follows a request
   a_drop_cause: assert property ( // RULE13
      @(posedge clk) disable iff (!resetn)
      evt_dropped |-> $past(evt_valid) || $past(vs_valid))
      else $error("drop reported without a request");

   // RULE1 zero code never shown
   a_code_nonzero: assert property ( // RULE1
      @(posedge clk) disable iff (!resetn)
      rec_valid |-> rec.record_type_code != perb_pkg::CODE_INVALID)
      else $error("record carries type code zero");

   // RULE1 zero code refused
   a_drop_zero: assert property ( // RULE1
      @(posedge clk) disable iff (!resetn)
      evt_valid && evt.code == perb_pkg::CODE_INVALID |=> evt_dropped)
      else $error("event with type code zero not dropped");

   // RULE2 core number copied
   a_core_copy: assert property ( // RULE2
      @(posedge clk) disable iff (!resetn)
      (take_vs || take_evt) |=> rec.core_number == $past(core_number_field))
      else $error("core number not copied");

   // RULE3 generic fields in place
   a_evt_layout: assert property ( // RULE3
      @(posedge clk) disable iff (!resetn)
      take_evt && evt.code != perb_pkg::CODE_INSTRET
      |=> rec.record_type_code == $past(evt.code)
         && rec.flags == $past(evt.flags) && rec.data == $past(evt.data)
         && rec.extra == $past(evt.extra))
      else $error("generic record fields misplaced");

   // RULE4 address passed unchanged
   a_evt_addr: assert property ( // RULE4
      @(posedge clk) disable iff (!resetn)
      take_evt |=> rec.instr_addr == $past(evt.instr_addr))
      else $error("event instruction address altered");

   // RULE11 reserved fields zero
   a_reserved_zero: assert property ( // RULE11
      @(posedge clk) disable iff (!resetn)
      take_evt && evt.code == perb_pkg::CODE_INSTRET
      |=> rec.flags == 16'h0 && rec.data == 32'h0 && rec.extra == 64'h0)
      else $error("retired-instruction record has reserved bits set");

   // RULE5 timestamp off gives zero
   a_ts_zero: assert property ( // RULE5
      @(posedge clk) disable iff (!resetn)
      (take_vs || take_evt) && !ts_enable |=> rec.timestamp == 64'h0)
      else $error("timestamp not zero when disabled");

   // RULE12 timestamp zero-extended
   a_ts_extend: assert property ( // RULE12
      @(posedge clk) disable iff (!resetn)
      (take_vs || take_evt) && ts_enable
      |=> rec.timestamp[63:56] == 8'h00
         && rec.timestamp[55:0] == $past(perf_timestamp_counter))
      else $error("timestamp not zero-extended");

   // RULE7 count down per sample
   a_vs_decrement: assert property ( // RULE7
      @(posedge clk) disable iff (!resetn)
      vs_valid && !cnt_load
      |=> vs_counter == $past(vs_counter) - 32'h0000_0001)
      else $error("value-sample counter did not decrement");

   // RULE7 reload wins
   a_load_wins: assert property ( // RULE7
      @(posedge clk) disable iff (!resetn)
      cnt_load |=> vs_counter == $past(cnt_load_value))
      else $error("counter reload not applied");

   // RULE7 idle counter holds
   a_counter_hold: assert property ( // RULE7
      @(posedge clk) disable iff (!resetn)
      !vs_valid && !cnt_load |=> $stable(vs_counter))
      else $error("counter moved without a sample");

   // RULE7 step to negative emits
   a_vs_underflow: assert property ( // RULE7
      @(posedge clk) disable iff (!resetn)
      vs_valid && !cnt_load && vs_counter == 32'h0000_0000
         && (!rec_valid || rec_ready)
      |=> rec_valid && rec.record_type_code == perb_pkg::CODE_VALSAMPLE)
      else $error("underflow did not emit a value-sample record");

   // RULE7 negative counter stays quiet
   a_vs_once: assert property ( // RULE7
      @(posedge clk) disable iff (!resetn)
      vs_valid && !cnt_load && !evt_valid
         && vs_counter[perb_pkg::CNT_BITS-1]
      |=> !rec_valid || $stable(rec))
      else $error("counter already negative emitted a record");

   // RULE6 value-sample code and flags
   a_vs_emits: assert property ( // RULE6
      @(posedge clk) disable iff (!resetn)
      take_vs |=> rec_valid
         && rec.record_type_code == perb_pkg::CODE_VALSAMPLE
         && rec.flags == $past(vs.imm)
         && rec.instr_addr == $past(vs.instr_addr))
      else $error("value-sample record wrong");

   // RULE10 value-sample address
   a_vs_addr: assert property ( // RULE10
      @(posedge clk) disable iff (!resetn)
      take_vs |=> rec.instr_addr == $past(vs.instr_addr))
      else $error("value-sample instruction address wrong");

   // RULE9 register or memory operand
   a_vs_operands: assert property ( // RULE9
      @(posedge clk) disable iff (!resetn)
      take_vs |=> rec.data == $past(vs.regmem)
         && (!$past(vs.legacy_mode) || rec.extra[63:32] == 32'h0))
      else $error("value-sample operands wrong");

   // RULE9 register operand extension
   a_vs_extra: assert property ( // RULE9
      @(posedge clk) disable iff (!resetn)
      take_vs |=> rec.extra == ($past(vs.legacy_mode)
         ? {32'h0000_0000, $past(vs.regval[31:0])} : $past(vs.regval)))
      else $error("value-sample register operand wrong");

   c_vs_record: cover property (@(posedge clk) disable iff (!resetn)
      take_vs);
   c_evt_record: cover property (@(posedge clk) disable iff (!resetn)
      take_evt);
   c_backpressure: cover property (@(posedge clk) disable iff (!resetn)
      rec_valid && !rec_ready ##1 rec_valid && !rec_ready ##1 rec_ready);
   c_vs_beats_evt: cover property (@(posedge clk) disable iff (!resetn)
      take_vs && evt_valid);
   c_legacy_sample: cover property (@(posedge clk) disable iff (!resetn)
      take_vs && vs.legacy_mode);

endmodule

`default_nettype wire

/* File: dv/perb_store_model.sv */
// perb_store_model: store stage that takes records from the builder.
// assumes: shares clk with the builder; the bench drives stall.
`timescale 1ns/1ps
`default_nettype none
module perb_store_model
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       stall,
   input  wire logic       rec_valid,
   output var  logic       rec_ready,
   output var  logic [7:0] n_stored
);
   // accept only on valid and ready
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rec_ready <= 1'b0;
         n_stored  <= 8'h00;
      end
      else
      begin
         rec_ready <= !stall;
         if (rec_valid && rec_ready)
            n_stored <= n_stored + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// tb_top: scenarios for the record builder against the store model.
// assumes: inputs change at the falling edge; ready is registered.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                clk, resetn, ts_enable, evt_valid, vs_valid;
   logic                cnt_load, stall, rec_valid, rec_ready, evt_dropped;
   logic [7:0]          core_number_field, n_stored;
   logic [55:0]         perf_timestamp_counter;
   logic [31:0]         cnt_load_value, vs_counter;
   perb_pkg::perb_evt_t evt;
   perb_pkg::perb_vs_t  vs;
   perb_pkg::perb_rec_t rec, exp;
   int                  n_fail, comparisons;
   perb_builder i_dut (.clk(clk), .resetn(resetn),
      .core_number_field(core_number_field), .ts_enable(ts_enable),
      .perf_timestamp_counter(perf_timestamp_counter),
      .evt_valid(evt_valid), .evt(evt), .vs_valid(vs_valid), .vs(vs),
      .cnt_load(cnt_load), .cnt_load_value(cnt_load_value),
      .rec_valid(rec_valid), .rec(rec), .rec_ready(rec_ready),
      .evt_dropped(evt_dropped), .vs_counter(vs_counter));
   perb_store_model i_store (.clk(clk), .resetn(resetn), .stall(stall),
      .rec_valid(rec_valid), .rec_ready(rec_ready), .n_stored(n_stored));
   task automatic chk(input logic [255:0] got, input logic [255:0] want);
      comparisons++;
      if (got !== want)
      begin
         n_fail++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic results;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [63:0] tsx();
      return ts_enable ? {8'h00, perf_timestamp_counter} : 64'h0;
   endfunction
   // underflow from a loaded zero; legacy drops the upper operand half
   task automatic t_vs(input logic legacy, input logic ts_on);
      @(negedge clk);
      ts_enable = ts_on;
      cnt_load = 1'b1;
      cnt_load_value = 32'h0000_0000;
      @(negedge clk);
      cnt_load = 1'b0;
      vs_valid = 1'b1;
      vs = '{16'hA5C3, 32'h1357_9BDF, 64'hFEDC_BA98_7654_3210,
             64'h0000_7FFF_0040_1000, legacy};
      exp = '{tsx(), legacy ? {32'h0, vs.regval[31:0]} : vs.regval,
              vs.instr_addr, vs.regmem, vs.imm, core_number_field,
              perb_pkg::CODE_VALSAMPLE};
      @(negedge clk);
      chk(rec_valid, 1'b1);
      chk(rec, exp);
      chk(vs_counter, 32'hFFFF_FFFF);
      // a second sample below zero must not emit again
      @(negedge clk);
      vs_valid = 1'b0;
      chk(rec_valid, 1'b0);
      chk(vs_counter, 32'hFFFF_FFFE);
   endtask
   // a load beats a sample; a sample above zero only counts down
   task automatic t_count;
      @(negedge clk);
      cnt_load = 1'b1;
      vs_valid = 1'b1;
      cnt_load_value = 32'h0000_0002;
      @(negedge clk);
      cnt_load = 1'b0;
      @(negedge clk);
      vs_valid = 1'b0;
      chk(vs_counter, 32'h0000_0001);
      chk(rec_valid, 1'b0);
      // sample and event together: the sample wins, the event is dropped
      cnt_load = 1'b1;
      cnt_load_value = 32'h0000_0000;
      @(negedge clk);
      cnt_load = 1'b0;
      vs_valid = 1'b1;
      evt_valid = 1'b1;
      evt = '{perb_pkg::CODE_BRRET, 16'h0, 32'h0, 64'h0, 64'h0};
      @(negedge clk);
      vs_valid = 1'b0;
      evt_valid = 1'b0;
      chk(rec.record_type_code, perb_pkg::CODE_VALSAMPLE);
      chk(evt_dropped, 1'b1);
   endtask
   // back-to-back generic codes, then one record held under stall
   task automatic t_evt(input logic hold);
      logic [7:0] c [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hFF, 8'h03};
      logic       instret;
      stall = hold;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
         if (i > 0)
            chk(rec, exp);
         if (hold && i > 1)
            chk(evt_dropped, i == 2);
         if (i < 7 && (!hold || i == 0))
         begin
            evt = '{c[i], 16'h0010, 32'hCAFE_0000, 64'h0040_2000,
                    64'h0040_3000};
            // retired-instruction records keep only the address
            instret = c[i] == perb_pkg::CODE_INSTRET;
            exp = '{tsx(), instret ? 64'h0 : evt.extra, evt.instr_addr,
                    instret ? 32'h0 : evt.data, instret ? 16'h0 : evt.flags,
                    core_number_field, c[i]};
         end
         evt_valid = (i < 7) && (!hold || i < 2);
         @(negedge clk);
      end
      stall = 1'b0;
      evt = '{8'h00, 16'h0, 32'h0, 64'h0, 64'h0};
      evt_valid = 1'b1;
      @(negedge clk);
      evt_valid = 1'b0;
      chk(evt_dropped, 1'b1);
      repeat (3) @(negedge clk);
      chk(rec_valid, 1'b0);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      {resetn, ts_enable, evt_valid, vs_valid, cnt_load, stall} = '0;
      core_number_field = 8'h5A;
      perf_timestamp_counter = 56'h12_3456_789A_BCDE;
      cnt_load_value = 32'h0;
      evt = '0;
      vs = '0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      t_vs(1'b0, 1'b1);
      core_number_field = 8'h03;
      t_vs(1'b1, 1'b0);
      t_count;
      t_evt(1'b0);
      ts_enable = 1'b1;
      t_evt(1'b1);
      chk(n_stored, 8'h0B);
      results;
   end
   initial
   begin
      repeat (2000) @(posedge clk);
      n_fail++;
      results;
   end
endmodule
`default_nettype wire
